// *** hw/flash_seq_params.svh ***
/*
  Constants for the flash erase/program sequencer controller: command codes,
  status bit positions and timing counts at the 20 MHz reference clock.
  Assumes inclusion by bare name from the design modules.
*/
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// Command codes written on the flash data bus.
`define CMD_ERASE_SETUP   8'h20
`define CMD_CONFIRM       8'hd0
`define CMD_SUSPEND       8'hb0
`define CMD_READ_STATUS   8'h70
`define CMD_READ_ARRAY    8'hff
`define CMD_PROG_SETUP    8'h40
`define CMD_PROG_SETUP2   8'h10
`define CMD_CLEAR_STATUS  8'h50

// Status register bit positions.
`define BIT_READY      7
`define BIT_SUSPENDED  6
`define BIT_ERASE_ERR  5
`define BIT_PROG_ERR   4
`define BIT_VPP_LOW    3

// Status image after reset or clear: only the ready bit is set.
`define STATUS_INIT    8'h80

// Bus cycle phase timing in nanoseconds and derived clock counts.
`define CLK_PERIOD_NS  50
`define PHASE_NS       150
`define PHASE_CYC      (((`PHASE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CNT_W          4
`define CNT_ONE        4'h1
`define CNT_ZERO       4'h0

`endif

// *** hw/flash_seq_pkg.sv ***
/*
  Types for the flash sequencer controller: operation codes and states.
  Assumes the params header is on the include path.
*/
package flash_seq_pkg;
  // Operations requested on the user port.
  typedef enum logic [2:0] {
    OP_ERASE   = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_SUSPEND = 3'h2,
    OP_RESUME  = 3'h3,
    OP_CLEAR   = 3'h4,
    OP_READ    = 3'h5,
    OP_STATUS  = 3'h6
  } op_e;

  // Controller sequence states.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CMD1    = 4'h1,
    ST_CMD2    = 4'h2,
    ST_POLLCMD = 4'h3,
    ST_POLL    = 4'h4,
    ST_ARRAY   = 4'h5,
    ST_READ    = 4'h6,
    ST_DONE    = 4'h7
  } state_e;
endpackage : flash_seq_pkg

// *** hw/flash_bus_cycle.sv ***
/*
  One asynchronous SRAM-style bus cycle on the flash pins: a write (chip and
  write enable low around stable data) or a read (chip and output enable low,
  data captured at the end of the strobe). Each phase lasts a fixed number of clocks.
  Assumes the read data input is already synchronised by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_params.svh"

module flash_bus_cycle (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Request side
  input  wire logic        start,
  input  wire logic        isWrite,
  input  wire logic [19:0] reqAddr,
  input  wire logic [7:0]  reqData,
  output logic             cycleDone,
  output logic [7:0]       readData,
  // Flash pins
  output logic [19:0]      flashAddr,
  output logic [7:0]       flashDataOut,
  output logic             flashDataOe_n,
  output logic             chipEnable_n,
  output logic             outputEnable_n,
  output logic             writeEnable_n,
  input  wire logic [7:0]  flashDataIn
);

  typedef enum logic [1:0] {
    PH_IDLE   = 2'h0,
    PH_SETUP  = 2'h1,
    PH_STROBE = 2'h2,
    PH_HOLD   = 2'h3
  } phase_e;

  phase_e                phase_reg, phase_next;
  logic [`CNT_W-1:0]     cnt_reg, cnt_next;
  logic                  wr_reg, wr_next;
  logic [19:0]           addr_reg, addr_next;
  logic [7:0]            wdata_reg, wdata_next;
  logic [7:0]            rdata_reg, rdata_next;
  logic                  done_reg, done_next;

  // Next-state logic: setup, strobe, hold, each a fixed phase length.
  always_comb begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    wr_next    = wr_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    done_next  = 1'b0;
    case (phase_reg)
      PH_IDLE: begin
        if (start) begin
          phase_next = PH_SETUP;
          cnt_next   = `CNT_W'(`PHASE_CYC);
          wr_next    = isWrite;
          addr_next  = reqAddr;
          wdata_next = reqData;
        end
      end
      PH_SETUP, PH_STROBE, PH_HOLD: begin
        if (cnt_reg > `CNT_ONE) begin
          cnt_next = cnt_reg - `CNT_ONE;
        end else begin
          cnt_next = `CNT_W'(`PHASE_CYC);
          if (phase_reg == PH_SETUP) begin
            phase_next = PH_STROBE;
          end else if (phase_reg == PH_STROBE) begin
            phase_next = PH_HOLD;
            // Sample at the end of the strobe while data is valid.
            rdata_next = flashDataIn;
          end else begin
            phase_next = PH_IDLE;
            done_next  = 1'b1;
          end
        end
      end
      default: phase_next = PH_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= `CNT_ZERO;
      wr_reg    <= 1'b0;
      addr_reg  <= 20'h00000;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      done_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      done_reg  <= done_next;
    end
  end

  // Pin drive; data is driven for the whole write so the hold is safe.
  assign cycleDone      = done_reg;
  assign readData       = rdata_reg;
  assign flashAddr      = addr_reg;
  assign flashDataOut   = wdata_reg;
  assign flashDataOe_n  = !(wr_reg && phase_reg != PH_IDLE);
  assign chipEnable_n   = (phase_reg == PH_IDLE);
  assign writeEnable_n  = !(wr_reg && phase_reg == PH_STROBE);
  assign outputEnable_n = !(!wr_reg && phase_reg != PH_IDLE);

endmodule : flash_bus_cycle
`default_nettype wire

// *** hw/flash_seq_ctrl.sv ***
/*
  Host-side controller for a parallel NOR flash with an internal erase and
  program sequencer. Takes operations on a user port, issues the two-step
  command sequences, polls readiness and returns the status byte, or the array byte for a read.
  Assumes the flash pins are wired directly and the data bus resolved
  outside from the output enable; readyBusyIn arrives asynchronously.
*/
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_params.svh"

module flash_seq_ctrl (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // User request port
  input  wire logic                reqValid,
  output logic                     reqReady,
  input  wire flash_seq_pkg::op_e  reqOp,
  input  wire logic [19:0]         reqAddr,
  input  wire logic [7:0]          reqData,
  // User answer port
  output logic                     respValid,
  output logic [7:0]               respData,
  output logic                     supplyLowErr,
  output logic                     sequenceErr,
  output logic                     eraseErr,
  output logic                     programErr,
  output logic                     eraseSuspended,
  // Flash pins
  output logic [19:0]              flashAddr,
  output logic [7:0]               flashDataOut,
  output logic                     flashDataOe_n,
  input  wire logic [7:0]          flashDataIn,
  output logic                     chipEnable_n,
  output logic                     outputEnable_n,
  output logic                     writeEnable_n,
  output logic                     powerdownReset_n,
  input  wire logic                readyBusyIn
);

  flash_seq_pkg::state_e state_reg, state_next;
  flash_seq_pkg::op_e    op_reg, op_next;
  logic [19:0]           addr_reg, addr_next;
  logic [7:0]            data_reg, data_next;
  logic [7:0]            resp_reg, resp_next;
  logic                  respV_reg, respV_next;
  logic [7:0]            status_reg, status_next;
  logic                  cycStart;
  logic                  cycWrite;
  logic [7:0]            cycData;
  logic                  cycDone;
  logic [7:0]            cycRead;
  logic [2:0]            rbySync_reg;
  logic                  rbyStable_reg, rbyStable_next;
  logic                  suspReq_reg, suspReq_next;

  // Decode: which error the status byte reports.
  function automatic logic [3:0] decode_status(input logic [7:0] s);
    logic both;
    both = s[`BIT_ERASE_ERR] && s[`BIT_PROG_ERR];
    decode_status = {s[`BIT_VPP_LOW], both,
                     s[`BIT_ERASE_ERR] && !both,
                     s[`BIT_PROG_ERR] && !both};
  endfunction : decode_status

  ////////////////////////////////////////////////////////////////////////////
  // Ready pin synchroniser: three flops, change taken when last two agree.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rbySync_reg   <= 3'h0;
      rbyStable_reg <= 1'b0;
    end else begin
      rbySync_reg   <= {rbySync_reg[1:0], readyBusyIn};
      rbyStable_reg <= rbyStable_next;
    end
  end

  // Filtered ready level.
  always_comb begin
    rbyStable_next = rbyStable_reg;
    if (rbySync_reg[1] == rbySync_reg[2]) begin
      rbyStable_next = rbySync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence next state. Each command is one write bus cycle; polling is a
  // status read repeated until the ready bit and the ready pin both show ready.
  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    addr_next   = addr_reg;
    data_next   = data_reg;
    resp_next   = resp_reg;
    respV_next  = 1'b0;
    status_next = status_reg;
    suspReq_next = suspReq_reg;
    cycStart    = 1'b0;
    cycWrite    = 1'b1;
    cycData     = `CMD_READ_STATUS;
    case (state_reg)
      flash_seq_pkg::ST_IDLE: begin
        if (reqValid) begin
          op_next    = reqOp;
          addr_next  = reqAddr;
          data_next  = reqData;
          state_next = flash_seq_pkg::ST_CMD1;
        end
      end
      flash_seq_pkg::ST_CMD1: begin
        cycStart = 1'b1;
        case (op_reg)
          flash_seq_pkg::OP_ERASE:   cycData = `CMD_ERASE_SETUP;
          flash_seq_pkg::OP_PROGRAM: cycData = `CMD_PROG_SETUP;
          flash_seq_pkg::OP_SUSPEND: cycData = `CMD_SUSPEND;
          flash_seq_pkg::OP_RESUME:  cycData = `CMD_CONFIRM;
          flash_seq_pkg::OP_CLEAR:   cycData = `CMD_CLEAR_STATUS;
          flash_seq_pkg::OP_READ:    cycData = `CMD_READ_ARRAY;
          default:                   cycData = `CMD_READ_STATUS;
        endcase
        state_next = flash_seq_pkg::ST_CMD2;
      end
      flash_seq_pkg::ST_CMD2: begin
        if (cycDone) begin
          case (op_reg)
            flash_seq_pkg::OP_ERASE, flash_seq_pkg::OP_PROGRAM: begin
              cycStart   = 1'b1;
              cycData    = (op_reg == flash_seq_pkg::OP_ERASE) ?
                           `CMD_CONFIRM : data_reg;
              state_next = flash_seq_pkg::ST_POLLCMD;
            end
            flash_seq_pkg::OP_READ: begin
              cycStart   = 1'b1;
              cycWrite   = 1'b0;
              state_next = flash_seq_pkg::ST_READ;
            end
            flash_seq_pkg::OP_CLEAR: begin
              status_next = `STATUS_INIT;
              state_next  = flash_seq_pkg::ST_DONE;
            end
            default: begin
              state_next = flash_seq_pkg::ST_POLLCMD;
              cycStart   = 1'b1;
            end
          endcase
        end
      end
      flash_seq_pkg::ST_POLLCMD: begin
        if (cycDone) begin
          cycStart   = 1'b1;
          cycData    = `CMD_READ_STATUS;
          state_next = flash_seq_pkg::ST_POLL;
        end
      end
      flash_seq_pkg::ST_POLL: begin
        suspReq_next = suspReq_reg || (reqValid && reqReady);
        if (cycDone) begin
          if (cycRead[`BIT_READY] && rbyStable_reg) begin
            status_next = cycRead;
            state_next  = (op_reg == flash_seq_pkg::OP_SUSPEND &&
                           cycRead[`BIT_SUSPENDED]) ?
                          flash_seq_pkg::ST_ARRAY : flash_seq_pkg::ST_DONE;
          end else if (suspReq_reg) begin
            // The suspend's answer stands in for the paused erase's.
            op_next      = flash_seq_pkg::OP_SUSPEND;
            suspReq_next = 1'b0;
            state_next   = flash_seq_pkg::ST_CMD1;
          end else begin
            // Re-reading toggles chip enable, refreshing the status byte.
            cycStart = 1'b1;
            cycWrite = 1'b0;
          end
        end
      end
      flash_seq_pkg::ST_ARRAY: begin
        cycStart   = 1'b1;
        cycData    = `CMD_READ_ARRAY;
        state_next = flash_seq_pkg::ST_DONE;
      end
      flash_seq_pkg::ST_READ: begin
        if (cycDone) begin
          resp_next  = cycRead;
          state_next = flash_seq_pkg::ST_DONE;
        end
      end
      flash_seq_pkg::ST_DONE: begin
        if (chipEnable_n) begin
          if (op_reg != flash_seq_pkg::OP_READ) begin
            resp_next = status_reg;
          end
          respV_next   = 1'b1;
          suspReq_next = 1'b0;
          state_next   = flash_seq_pkg::ST_IDLE;
        end
      end
      default: state_next = flash_seq_pkg::ST_IDLE;
    endcase
  end

  // Sequence registers; status mirrors the device's reset value.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg  <= flash_seq_pkg::ST_IDLE;
      op_reg     <= flash_seq_pkg::OP_STATUS;
      addr_reg   <= 20'h00000;
      data_reg   <= 8'h00;
      resp_reg   <= 8'h00;
      respV_reg  <= 1'b0;
      status_reg <= `STATUS_INIT;
      suspReq_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      op_reg     <= op_next;
      addr_reg   <= addr_next;
      data_reg   <= data_next;
      resp_reg   <= resp_next;
      respV_reg  <= respV_next;
      status_reg <= status_next;
      suspReq_reg <= suspReq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin-level bus cycles; the block address is reused for both writes.
  flash_bus_cycle cycle_u (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .start          (cycStart),
    .isWrite        (cycWrite),
    .reqAddr        (addr_reg),
    .reqData        (cycData),
    .cycleDone      (cycDone),
    .readData       (cycRead),
    .flashAddr      (flashAddr),
    .flashDataOut   (flashDataOut),
    .flashDataOe_n  (flashDataOe_n),
    .chipEnable_n   (chipEnable_n),
    .outputEnable_n (outputEnable_n),
    .writeEnable_n  (writeEnable_n),
    .flashDataIn    (flashDataIn)
  );

  // Outputs. Power-down reset held low during controller reset aborts any
  // operation in the device, which clears its status too.
  // status decode
  assign {supplyLowErr, sequenceErr, eraseErr, programErr} =
    decode_status(status_reg);
  assign eraseSuspended   = status_reg[`BIT_SUSPENDED];
  // mid-erase only a suspend is taken
  assign reqReady         = (state_reg == flash_seq_pkg::ST_IDLE) ||
    (state_reg == flash_seq_pkg::ST_POLL && !suspReq_reg &&
     op_reg == flash_seq_pkg::OP_ERASE && reqOp == flash_seq_pkg::OP_SUSPEND);
  assign respValid        = respV_reg;
  assign respData         = resp_reg;
  assign powerdownReset_n = !rst;

endmodule : flash_seq_ctrl
`default_nettype wire

// *** verification/flash_seq_asserts.sv ***
/* Port checker for flash_seq_ctrl.
   Assumes it is bound onto the controller; one clock, sync reset. */
`timescale 1ns/100ps
`default_nettype none
module flash_seq_asserts (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // User side
  input wire logic        reqReady,
  input wire logic        respValid,
  input wire logic        supplyLowErr,
  input wire logic        sequenceErr,
  input wire logic        eraseErr,
  input wire logic        programErr,
  input wire logic        eraseSuspended,
  // Flash pins
  input wire logic [19:0] flashAddr,
  input wire logic [7:0]  flashDataOut,
  input wire logic        flashDataOe_n,
  input wire logic        chipEnable_n,
  input wire logic        outputEnable_n,
  input wire logic        writeEnable_n,
  input wire logic        powerdownReset_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  // Pin and answer relations; a write strobe must never meet a read strobe.
  a_pd_follows: assert property (powerdownReset_n)
    else $error("power-down held low outside reset");
  a_write_drives: assert property (!writeEnable_n |-> !chipEnable_n && !flashDataOe_n)
    else $error("write strobe without select or data drive");
  a_write_stable: assert property (!writeEnable_n && $past(!writeEnable_n) |-> $stable(flashDataOut) && $stable(flashAddr))
    else $error("data or address moved under write strobe");
  a_we_width: assert property ($fell(writeEnable_n) |-> (!writeEnable_n)[*3] ##1 writeEnable_n)
    else $error("write strobe not three cycles wide");
  a_rw_exclusive: assert property (!(!outputEnable_n && !writeEnable_n))
    else $error("read and write strobes together");
  a_read_released: assert property (!outputEnable_n |-> flashDataOe_n)
    else $error("data driven during read");
  a_err_exclusive: assert property (sequenceErr |-> !eraseErr && !programErr)
    else $error("sequence error decoded with single error");
  a_err_single: assert property (eraseErr |-> !programErr)
    else $error("erase and program error both alone");
  a_resp_pulse: assert property (respValid |=> !respValid && reqReady)
    else $error("answer not a pulse followed by ready");
  // Main scenarios reached.
  c_erase_err: cover property (respValid && eraseErr);
  c_seq_err: cover property (respValid && sequenceErr);
  c_low_err: cover property (respValid && supplyLowErr);
  c_suspend: cover property (respValid && eraseSuspended);
endmodule : flash_seq_asserts

bind flash_seq_ctrl flash_seq_asserts u_chk (.ref_clk, .rst, .reqReady,
  .respValid, .supplyLowErr, .sequenceErr, .eraseErr, .programErr,
  .eraseSuspended, .flashAddr, .flashDataOut, .flashDataOe_n, .chipEnable_n,
  .outputEnable_n, .writeEnable_n, .powerdownReset_n);
`default_nettype wire

// *** verification/flash_device_model.sv ***
/* Behavioural flash device: command decoder, status byte, timed sequencer.
   Assumes the pins of flash_seq_ctrl; ref_clk times the sequencer and samples the write strobe. */
`timescale 1ns/100ps
`default_nettype none
module flash_device_model #(
  parameter int ERASE_CYC = 200,
  parameter int PROG_CYC  = 40
) (
  // Timing and test controls
  input  wire logic        ref_clk,
  input  wire logic        supplyLow,
  input  wire logic        opFail,
  // Flash pins
  input  wire logic [19:0] flashAddr,
  input  wire logic [7:0]  flashDataOut,
  input  wire logic        flashDataOe_n,
  input  wire logic        chipEnable_n,
  input  wire logic        outputEnable_n,
  input  wire logic        writeEnable_n,
  input  wire logic        powerdownReset_n,
  output var logic [7:0]   flashDataIn,
  output var logic         readyBusyIn
);
  logic [7:0]  mem [logic [19:0]];
  logic [7:0]  cmdQ;
  logic [7:0]  lastQ = 8'h00;
  logic [19:0] adrQ;
  logic        weQ, susp, eErr, pErr, vLow, statMode;
  logic [1:0]  pend;
  int          busyCnt;
  logic [7:0]  statusByte;
  //////////////////////////////////////////////////////////////////////////////
  // status layout
  assign statusByte = {busyCnt == 0 || susp, susp, eErr, pErr, vLow, 3'h0};
  assign readyBusyIn = busyCnt == 0 || susp || !powerdownReset_n;
  // Released bus shows the inverse of the last value, never a stale copy.
  always @* begin
    if (!flashDataOe_n) flashDataIn = flashDataOut;
    else if (!chipEnable_n && !outputEnable_n)
      flashDataIn = statMode ? statusByte
                  : (mem.exists(flashAddr) ? mem[flashAddr] : 8'hff);
    else flashDataIn = ~lastQ;
  end
  // Command taken at the rising write strobe.
  task automatic accept(input logic [7:0] c, input logic [19:0] a);
    statMode <= 1'b1;
    pend <= 2'h0;
    if (pend == 2'h1 && c != 8'hd0) begin
      eErr <= 1'b1;
      pErr <= 1'b1;
    end else if (pend != 2'h0 && !vLow) begin
      if (supplyLow || opFail) begin
        vLow <= vLow | supplyLow;
        if (pend == 2'h1) eErr <= 1'b1;
        else pErr <= 1'b1;
      end
      if (!supplyLow) begin
        busyCnt <= pend == 2'h1 ? ERASE_CYC : PROG_CYC;
        if (pend == 2'h1) foreach (mem[k]) begin
          if (k[19:16] == a[19:16]) mem[k] = 8'hff;
        end
        else mem[a] = c;
      end
    end else if (pend == 2'h0) case (c)
      8'h20: pend <= 2'h1;
      8'h40, 8'h10: pend <= 2'h2;
      8'hb0: susp <= busyCnt != 0;
      8'hd0: susp <= 1'b0;
      8'h50: {eErr, pErr, vLow} <= 3'h0;
      8'hff: statMode <= 1'b0;
      default: ;
    endcase
  endtask : accept
  always @(posedge ref_clk) begin
    weQ <= writeEnable_n;
    if (!chipEnable_n && !outputEnable_n) lastQ <= flashDataIn;
    if (!writeEnable_n && !chipEnable_n) begin
      cmdQ <= flashDataOut;
      adrQ <= flashAddr;
    end
    if (!powerdownReset_n) begin
      {busyCnt, susp, eErr, pErr, vLow, statMode} <= '0;
      pend <= 2'h0;
    end else if (writeEnable_n && !weQ) accept(cmdQ, adrQ);
    else if (busyCnt != 0 && !susp) busyCnt <= busyCnt - 1;
  end
endmodule : flash_device_model
`default_nettype wire

// *** verification/tb.sv ***
/* Self-checking bench for flash_seq_ctrl against the device model.
   Assumes the package and params header are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk, rst, reqValid, supplyLow, opFail;
  flash_seq_pkg::op_e reqOp;
  logic [19:0] reqAddr, flashAddr;
  logic [7:0]  reqData, respData, flashDataOut, flashDataIn;
  logic reqReady, respValid, supplyLowErr, sequenceErr, eraseErr;
  logic programErr, eraseSuspended, flashDataOe_n, chipEnable_n;
  logic outputEnable_n, writeEnable_n, powerdownReset_n, readyBusyIn;
  int   error_cnt = 0;
  int   n_compared = 0;
  flash_seq_ctrl i_dut (.ref_clk, .rst, .reqValid, .reqReady, .reqOp,
    .reqAddr, .reqData, .respValid, .respData, .supplyLowErr, .sequenceErr,
    .eraseErr, .programErr, .eraseSuspended, .flashAddr, .flashDataOut,
    .flashDataOe_n, .flashDataIn, .chipEnable_n, .outputEnable_n,
    .writeEnable_n, .powerdownReset_n, .readyBusyIn);
  flash_device_model #(.ERASE_CYC(200), .PROG_CYC(40)) i_dev (.ref_clk,
    .supplyLow, .opFail, .flashAddr, .flashDataOut, .flashDataOe_n,
    .chipEnable_n, .outputEnable_n, .writeEnable_n, .powerdownReset_n,
    .flashDataIn, .readyBusyIn);
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Fields first, as ready may depend on the operation; valid is raised
  // at a falling edge that sees ready, so one rising edge takes it.
  task automatic issue(input flash_seq_pkg::op_e op, input logic [19:0] a,
                       input logic [7:0] d);
    @(negedge ref_clk);
    reqOp = op;
    reqAddr = a;
    reqData = d;
    @(negedge ref_clk);
    while (reqReady !== 1'b1) @(negedge ref_clk);
    reqValid = 1'b1;
    @(negedge ref_clk);
    reqValid = 1'b0;
  endtask : issue
  // One operation: answer byte, then the held decode flags.
  task automatic t(input flash_seq_pkg::op_e op, input logic [19:0] a,
                   input logic [7:0] d, er, ef, input string nm);
    int n;
    logic [7:0] got;
    issue(op, a, d);
    n = 0;
    while (respValid !== 1'b1 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    // A missing answer ends the run as a failure.
    if (n >= 5000) begin
      error_cnt++;
      complete_run();
    end
    got = respData;
    @(negedge ref_clk);
    check({nm, " answer"}, got, er);
    check({nm, " flags"}, {3'h0, supplyLowErr, sequenceErr, eraseErr,
          programErr, eraseSuspended}, ef);
    $display("done: %s", nm);
  endtask : t
  // Bound on the whole run, well above the expected length.
  initial begin
    #(30000 * 50);
    error_cnt++;
    complete_run();
  end
  initial begin
    {rst, reqValid, supplyLow, opFail} = 4'h8;
    reqOp = flash_seq_pkg::OP_STATUS;
    reqAddr = 20'h00000;
    reqData = 8'h00;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    t(flash_seq_pkg::OP_STATUS, 20'h0, 8'h0, 8'h80, 8'h00, "reset");
    t(flash_seq_pkg::OP_PROGRAM, 20'h12345, 8'h5a, 8'h80, 8'h00, "prog");
    t(flash_seq_pkg::OP_READ, 20'h12345, 8'h0, 8'h5a, 8'h00, "read");
    t(flash_seq_pkg::OP_ERASE, 20'h10000, 8'h0, 8'h80, 8'h00, "erase");
    t(flash_seq_pkg::OP_READ, 20'h12345, 8'h0, 8'hff, 8'h00, "erased");
    opFail = 1'b1;
    t(flash_seq_pkg::OP_PROGRAM, 20'h20000, 8'h33, 8'h90, 8'h02, "pfail");
    opFail = 1'b0;
    t(flash_seq_pkg::OP_PROGRAM, 20'h20001, 8'h44, 8'h90, 8'h02, "psticky");
    t(flash_seq_pkg::OP_CLEAR, 20'h0, 8'h0, 8'h80, 8'h00, "clear");
    opFail = 1'b1;
    t(flash_seq_pkg::OP_ERASE, 20'h30000, 8'h0, 8'ha0, 8'h04, "efail");
    opFail = 1'b0;
    t(flash_seq_pkg::OP_ERASE, 20'h40000, 8'h0, 8'ha0, 8'h04, "esticky");
    opFail = 1'b1;
    t(flash_seq_pkg::OP_PROGRAM, 20'h40000, 8'h11, 8'hb0, 8'h08, "both");
    opFail = 1'b0;
    t(flash_seq_pkg::OP_CLEAR, 20'h0, 8'h0, 8'h80, 8'h00, "clear2");
    supplyLow = 1'b1;
    t(flash_seq_pkg::OP_ERASE, 20'h50000, 8'h0, 8'ha8, 8'h14, "vlow");
    supplyLow = 1'b0;
    t(flash_seq_pkg::OP_PROGRAM, 20'h12345, 8'h77, 8'ha8, 8'h14, "refuse");
    t(flash_seq_pkg::OP_READ, 20'h12345, 8'h0, 8'hff, 8'h14, "kept");
    t(flash_seq_pkg::OP_CLEAR, 20'h0, 8'h0, 8'h80, 8'h00, "clear3");
    // Suspend a running erase, read another block, then resume it.
    issue(flash_seq_pkg::OP_ERASE, 20'h70000, 8'h00);
    t(flash_seq_pkg::OP_SUSPEND, 20'h0, 8'h0, 8'hc0, 8'h01, "susp");
    t(flash_seq_pkg::OP_READ, 20'h40000, 8'h0, 8'h11, 8'h01, "away");
    t(flash_seq_pkg::OP_RESUME, 20'h0, 8'h0, 8'h80, 8'h00, "resume");
    // Reset in mid-erase, then the status must be back at its initial value.
    issue(flash_seq_pkg::OP_ERASE, 20'h60000, 8'h00);
    repeat (60) @(negedge ref_clk);
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    t(flash_seq_pkg::OP_STATUS, 20'h0, 8'h0, 8'h80, 8'h00, "abort");
    complete_run();
  end
endmodule : tb
`default_nettype wire
